// >>> sip_pkg.sv
// Shared constants and carriers of the switch ingress policy block.
// Assumes one core clock domain and a lookup engine that resolves the DA before a request.
package sip_pkg;

	localparam int          NUM_PORTS = 6;

	typedef enum logic [1:0] {
		SIP_ST_DISABLED   = 2'h0,
		SIP_ST_BLOCKING   = 2'h1,
		SIP_ST_LEARNING   = 2'h2,
		SIP_ST_FORWARDING = 2'h3
	} sip_port_state_t;

	localparam logic [1:0]  FMT_NORMAL       = 2'h0;
	localparam logic [1:0]  FMT_TRAILER      = 2'h1;

	localparam logic [3:0]  ADDR_MASK_BASE   = 4'h0;
	localparam logic [3:0]  ADDR_CTRL_BASE   = 4'h8;
	localparam logic [3:0]  ADDR_LAST_DEST   = 4'hE;

	localparam int          CTRL_STATE_LSB   = 0;
	localparam int          CTRL_TUNNEL_BIT  = 2;
	localparam int          CTRL_FMT_LSB     = 3;

	localparam int          TR_OVERRIDE_BIT  = 31;
	localparam int          TR_NOLEARN_BIT   = 30;
	localparam int          TR_NOCRC_BIT     = 29;
	localparam int          TR_FRAME_FLAG_A_BIT      = 28;
	localparam int          TR_DPV_LSB       = 8;

	localparam logic [3:0]  ES_MC_LOCKED     = 4'h7;
	localparam logic [3:0]  ES_MC_FRAME_FLAG_A       = 4'hE;
	localparam logic [3:0]  ES_UC_LOCKED     = 4'hF;

	localparam logic [2:0]  TRAILER_PORT_A   = 3'h4;
	localparam logic [2:0]  TRAILER_PORT_B   = 3'h5;
	localparam logic [10:0] TRAILER_BYTES    = 11'h004;
	localparam logic [10:0] MIN_FRAME_LEN    = 11'h040;
	localparam logic [10:0] MAX_FRAME_LEN    = 11'h5EE;

	localparam logic [1:0]  STRAP_SETTLE     = 2'h2;

	typedef struct packed {
		logic        valid;
		logic [2:0]  srcPort;
		logic [10:0] lenBytes;
		logic        fcsOk;
		logic        daHit;
		logic        daMulticast;
		logic [3:0]  daEntryState;
		logic [5:0]  daPortVector;
		logic [31:0] trailer;
	} sip_req_t;

	typedef struct packed {
		logic        valid;
		logic [5:0]  destPorts;
		logic        discard;
		logic        learnSa;
		logic        stripTrailer;
		logic        rewriteCrc;
		logic [10:0] adjLen;
		logic        lengthError;
		logic        mgmtFrame;
	} sip_res_t;

endpackage

// >>> sip_ingress_policy.sv
// Per-frame ingress policy: egress masks, port states, locked-DA tunnelling, CPU trailer.
// Assumes one request per frame from the MAC with the lookup result already attached,
// and a strap pin that is asynchronous to core_clk.
//
// Notes on behaviour
// - Per-port six-bit egress mask gates destinations.
// - Reset mask is all ones but own bit.
// - Own bit set allows hairpin back out.
// - Locked DA with tunnel enable bypasses mask.
// - Disabled port: no ingress, egress, learning.
// - Blocking port: management only, no learning.
// - Learning port: management only, learns good frames.
// - Forwarding port: everything passes, learns good frames.
// - Management means multicast locked DA state 0xE.
// - Management frames ignore masks, use DA vector.
// - Port state writable anytime, applies next frame; the strap load after reset overrides earlier and same-cycle writes.
// - Reset state forwarding, disabled if CPU strap.
// - Trailer mode only on ports 4 and 5.
// - Trailer stripped, CRC rewritten, four bytes shorter.
// - Length checks use trailer-stripped length.
// - Override clear ignores trailer vector and management.
// - Learn-disable bit stops learning regardless of override.
// - Ignore-checksum skips FCS test, regardless of override.
// - Override selects trailer vector; zero discards.
// - Override plus management bit passes blocked ports.
// - Zero DA vector discards a frame without override.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module sip_ingress_policy (
	input  wire logic            core_clk,
	input  wire logic            resetn,
	input  wire logic            switch_strap_select,
	input  wire logic [3:0]      regAddr,
	input  wire logic [7:0]      regWrData,
	input  wire logic            regWr,
	input  wire logic            regRd,
	output logic      [7:0]      regRdData,
	input  wire sip_pkg::sip_req_t frameReq,
	output sip_pkg::sip_res_t    frameRes
);
	import sip_pkg::*;

	// Frames in a given port state may pass only if the state allows their class.
	function automatic logic stateAdmits(input logic [1:0] st, input logic isMgmt);
		case (st)
			SIP_ST_FORWARDING: stateAdmits = 1'b1;
			SIP_ST_LEARNING:   stateAdmits = isMgmt;
			SIP_ST_BLOCKING:   stateAdmits = isMgmt;
			default:           stateAdmits = 1'b0;
		endcase
	endfunction

	function automatic logic stateLearns(input logic [1:0] st);
		stateLearns = (st == SIP_ST_LEARNING) || (st == SIP_ST_FORWARDING);
	endfunction

	function automatic logic trailerCapable(input logic [2:0] port);
		trailerCapable = (port == TRAILER_PORT_A) || (port == TRAILER_PORT_B);
	endfunction

	logic [5:0]  egressMask_reg [NUM_PORTS];
	logic [1:0]  spanning_port_state_reg  [NUM_PORTS];
	logic        tunnelEn_reg   [NUM_PORTS];
	logic [1:0]  fmtSel_reg     [NUM_PORTS];
	logic        strapMeta_reg;
	logic        strapSync_reg;
	logic [1:0]  settleCnt_reg;
	logic        strapLoad;
	logic [5:0]  lastDest_reg;
	logic [7:0]  rdNext;
	sip_res_t    resNext;

	// Two-stage synchroniser for the strap; only the second stage is read.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			strapMeta_reg <= 1'b0;
			strapSync_reg <= 1'b0;
		end else begin
			strapMeta_reg <= switch_strap_select;
			strapSync_reg <= strapMeta_reg;
		end
	end

	// The strap is caught once, after the synchroniser has settled past reset release.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			settleCnt_reg <= 2'h0;
		end else if (settleCnt_reg != 2'h3) begin
			settleCnt_reg <= settleCnt_reg + 2'h1;
		end
	end
	assign strapLoad = (settleCnt_reg == STRAP_SETTLE);

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			localparam logic [3:0] MASK_ADDR = ADDR_MASK_BASE + 4'(gp);
			localparam logic [3:0] CTRL_ADDR = ADDR_CTRL_BASE + 4'(gp);
			localparam logic [5:0] MASK_RST  = ~(6'h01 << gp);
			localparam logic       HAS_TRL   = trailerCapable(3'(gp));

			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					egressMask_reg[gp] <= MASK_RST;
				end else if (regWr && regAddr == MASK_ADDR) begin
					egressMask_reg[gp] <= regWrData[5:0];
				end
			end

			// Ports stay disabled until the strap is resolved, then take its default.
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					spanning_port_state_reg[gp] <= SIP_ST_DISABLED;
				end else if (strapLoad) begin
					spanning_port_state_reg[gp] <= strapSync_reg ? SIP_ST_DISABLED : SIP_ST_FORWARDING;
				end else if (regWr && regAddr == CTRL_ADDR) begin
					spanning_port_state_reg[gp] <= regWrData[CTRL_STATE_LSB +: 2];
				end
			end

			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					tunnelEn_reg[gp] <= 1'b0;
				end else if (regWr && regAddr == CTRL_ADDR) begin
					tunnelEn_reg[gp] <= regWrData[CTRL_TUNNEL_BIT];
				end
			end

			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					fmtSel_reg[gp] <= FMT_NORMAL;
				end else if (HAS_TRL && regWr && regAddr == CTRL_ADDR) begin
					fmtSel_reg[gp] <= regWrData[CTRL_FMT_LSB +: 2];
				end
			end
		end
	endgenerate

	always_comb begin
		rdNext = 8'h00;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (regAddr == ADDR_MASK_BASE + 4'(i)) begin
				rdNext = {2'h0, egressMask_reg[i]};
			end
			if (regAddr == ADDR_CTRL_BASE + 4'(i)) begin
				rdNext = {3'h0, fmtSel_reg[i], tunnelEn_reg[i], spanning_port_state_reg[i]};
			end
		end
		if (regAddr == ADDR_LAST_DEST) begin
			rdNext = {2'h0, lastDest_reg};
		end
	end

	// Read data stand only in the cycle after the read strobe; other cycles read zero.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= 8'h00;
		end else if (regRd) begin
			regRdData <= rdNext;
		end else begin
			regRdData <= 8'h00;
		end
	end

	// Frame decision, combinational from the request, registered into the result.
	always_comb begin
		logic [1:0]  inState;
		logic        trailerOn;
		logic        override;
		logic        lookupMgmt;
		logic        lookupLocked;
		logic        isMgmt;
		logic        crcSkip;
		logic        goodFrame;
		logic [5:0]  wantPorts;
		logic [5:0]  destPorts;
		logic [2:0]  srcIdx;
		inState      = SIP_ST_DISABLED;
		srcIdx       = 3'h0;
		trailerOn    = 1'b0;
		override     = 1'b0;
		lookupMgmt   = 1'b0;
		lookupLocked = 1'b0;
		isMgmt       = 1'b0;
		crcSkip      = 1'b0;
		goodFrame    = 1'b0;
		wantPorts    = 6'h00;
		destPorts    = 6'h00;
		resNext      = '0;
		if (frameReq.srcPort < 3'(NUM_PORTS)) begin
			srcIdx    = frameReq.srcPort;
			inState   = spanning_port_state_reg[frameReq.srcPort];
			trailerOn = trailerCapable(frameReq.srcPort) &&
				(fmtSel_reg[frameReq.srcPort] == FMT_TRAILER);
		end
		override   = trailerOn && frameReq.trailer[TR_OVERRIDE_BIT];
		lookupMgmt = frameReq.daHit && frameReq.daMulticast &&
			(frameReq.daEntryState == ES_MC_FRAME_FLAG_A);
		lookupLocked = frameReq.daHit && (frameReq.daMulticast ?
			(frameReq.daEntryState == ES_MC_LOCKED || frameReq.daEntryState == ES_MC_FRAME_FLAG_A) :
			(frameReq.daEntryState == ES_UC_LOCKED));
		isMgmt = override ? frameReq.trailer[TR_FRAME_FLAG_A_BIT] : lookupMgmt;
		crcSkip = trailerOn && frameReq.trailer[TR_NOCRC_BIT];
		resNext.stripTrailer = trailerOn;
		resNext.rewriteCrc   = trailerOn;
		resNext.adjLen = trailerOn ? (frameReq.lenBytes - TRAILER_BYTES) : frameReq.lenBytes;
		resNext.lengthError = (resNext.adjLen < MIN_FRAME_LEN) ||
			(resNext.adjLen > MAX_FRAME_LEN);
		goodFrame = !resNext.lengthError && (frameReq.fcsOk || crcSkip);
		if (override) begin
			wantPorts = frameReq.trailer[TR_DPV_LSB +: 6];
		end else if (lookupMgmt) begin
			wantPorts = frameReq.daPortVector;
		end else if (lookupLocked && tunnelEn_reg[srcIdx]) begin
			wantPorts = frameReq.daPortVector;
		end else begin
			wantPorts = frameReq.daPortVector & egressMask_reg[srcIdx];
		end
		for (int n = 0; n < NUM_PORTS; n++) begin
			destPorts[n] = wantPorts[n] && stateAdmits(spanning_port_state_reg[n], isMgmt);
		end
		if (!goodFrame || !stateAdmits(inState, isMgmt)) begin
			destPorts = 6'h00;
		end
		resNext.valid     = frameReq.valid;
		resNext.mgmtFrame = isMgmt;
		resNext.destPorts = destPorts;
		resNext.discard   = (destPorts == 6'h00);
		resNext.learnSa   = goodFrame && stateLearns(inState) &&
			!(trailerOn && frameReq.trailer[TR_NOLEARN_BIT]);
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			frameRes <= '0;
		end else if (frameReq.valid) begin
			frameRes <= resNext;
		end else begin
			frameRes <= '0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			lastDest_reg <= 6'h00;
		end else if (frameReq.valid) begin
			lastDest_reg <= resNext.destPorts;
		end
	end

endmodule

// >>> sip_cpu_mac.sv
// Model of the attached CPU MAC: builds the four trailer bytes of a frame it sends.
// Assumes the bench sets the flag nibble and the vector before it issues the frame.
`timescale 1ns/10ps
module sip_cpu_mac (
	input  wire logic [3:0]  flags,
	input  wire logic [5:0]  vec,
	output logic      [31:0] trailer
);
	import sip_pkg::*;
	always_comb begin
		trailer = 32'h0000_0000;
		{trailer[TR_OVERRIDE_BIT], trailer[TR_NOLEARN_BIT]} = flags[3:2];
		{trailer[TR_NOCRC_BIT], trailer[TR_FRAME_FLAG_A_BIT]} = flags[1:0];
		trailer[TR_DPV_LSB +: 6] = vec;
	end
endmodule

// >>> sip_policy_monitor.sv
// Checker of the policy block ports: answer timing, length, trailer and drop relations.
// Assumes one core clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module sip_policy_monitor (
	input wire logic              core_clk,
	input wire logic              resetn,
	input wire sip_pkg::sip_req_t frameReq,
	input wire sip_pkg::sip_res_t frameRes
);
	import sip_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	res_timing_a: assert property (frameReq.valid |=> frameRes.valid)
		else $error("missing answer");
	idle_quiet_a: assert property (!frameReq.valid |=> frameRes == '0)
		else $error("stray answer");
	drop_flag_a: assert property (frameRes.valid |-> frameRes.discard == !frameRes.destPorts)
		else $error("discard flag wrong");
	len_check_a: assert property (frameRes.valid |-> frameRes.lengthError ==
		(frameRes.adjLen < MIN_FRAME_LEN || frameRes.adjLen > MAX_FRAME_LEN))
		else $error("length flag wrong");
	bad_len_a: assert property (frameRes.valid && frameRes.lengthError |->
		frameRes.destPorts == 6'h00 && !frameRes.learnSa) else $error("bad length passed");
	no_strip_a: assert property (frameReq.valid && frameReq.srcPort < TRAILER_PORT_A |=>
		!frameRes.stripTrailer && frameRes.adjLen == $past(frameReq.lenBytes))
		else $error("strip on port 0..3");
	strip_crc_a: assert property (frameRes.valid && frameRes.stripTrailer |->
		frameRes.rewriteCrc && frameRes.adjLen == $past(frameReq.lenBytes) - TRAILER_BYTES)
		else $error("strip length wrong");
	mask_sub_a: assert property (frameReq.valid && frameReq.srcPort < TRAILER_PORT_A |=>
		(frameRes.destPorts & ~$past(frameReq.daPortVector)) == 6'h00)
		else $error("port outside vector");
	bad_fcs_a: assert property (frameReq.valid && !frameReq.fcsOk && frameReq.srcPort < 3'h4
		|=> frameRes.destPorts == 6'h00 && !frameRes.learnSa) else $error("bad fcs passed");
	frame_flag_a_class_a: assert property (frameReq.valid && frameReq.srcPort < TRAILER_PORT_A |=>
		frameRes.mgmtFrame == $past(frameReq.daHit && frameReq.daMulticast &&
		frameReq.daEntryState == ES_MC_FRAME_FLAG_A)) else $error("management class wrong");
	src_range_a: assert property (frameReq.valid && frameReq.srcPort > 3'h5 |=>
		frameRes.destPorts == 6'h00 && !frameRes.learnSa) else $error("bad port passed");
endmodule

// >>> sip_ingress_policy_bench.sv
// Self-checking bench of the ingress policy block: register and frame scenarios.
// Assumes the register map and trailer layout that the package and design declare.
`timescale 1ns/10ps
module sip_ingress_policy_bench;
	import sip_pkg::*;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        strap = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [7:0]  regWrData = 8'h00;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [7:0]  regRdData;
	sip_req_t    frameReqTb = '0;
	sip_req_t    frameReq;
	sip_res_t    frameRes;
	logic [3:0]  tFlags = 4'h0;
	logic [5:0]  tVec = 6'h00;
	logic [31:0] cpuTrailer;
	logic        rdSeen = 1'b0;
	logic        tMode = 1'b0;
	logic [19:0] fq[$];
	logic [7:0]  rq[$];
	int          failures = 0;
	int          nCompared = 0;
	int          k;
	logic [2:0]  rs;
	logic [5:0]  rv;
	always #20 core_clk = ~core_clk;
	sip_ingress_policy sip_ingress_policy_inst (.core_clk(core_clk), .resetn(resetn),
		.switch_strap_select(strap), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .frameReq(frameReq), .frameRes(frameRes));
	sip_cpu_mac sip_cpu_mac_inst (.flags(tFlags), .vec(tVec), .trailer(cpuTrailer));
	// The trailer field always carries what the CPU model builds.
	always_comb begin
		frameReq = frameReqTb;
		frameReq.trailer = cpuTrailer;
	end
	task automatic chk(input logic [19:0] s, input logic [19:0] e);
		nCompared++;
		if (s !== e) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && nCompared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		rq.push_back(e);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(posedge core_clk);
	endtask
	// Issues one frame; a trailer is stripped only on ports 4 and 5 in trailer format.
	task automatic frm(input logic [2:0] s, input logic [3:0] es, input logic [5:0] v,
		input logic [5:0] d, input logic l, input logic [3:0] fl = '0,
		input logic [5:0] tv = '0, input logic [10:0] n = 11'h064, input logic ok = '1);
		logic st;
		st = tMode && s[2] && !s[1];
		tFlags <= fl;
		tVec <= tv;
		frameReqTb <= '{valid: 1'b1, srcPort: s, lenBytes: n, fcsOk: ok, daHit: es != 4'h0,
			daMulticast: es == 4'hE, daEntryState: es, daPortVector: v, trailer: 32'h0};
		fq.push_back({d == 6'h00, d, l, st, st ? n - TRAILER_BYTES : n});
		@(posedge core_clk);
		frameReqTb.valid <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic do_reset(input logic sv);
		strap <= sv;
		resetn <= 1'b0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (5) @(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		if (rdSeen)
			chk({12'h000, regRdData}, {12'h000, rq.pop_front()});
		else if (resetn)
			chk({12'h000, regRdData}, 20'h00000);
		if (frameRes.valid === 1'b1)
			chk({frameRes.discard, frameRes.destPorts, frameRes.learnSa, frameRes.stripTrailer,
				frameRes.adjLen}, fq.size() > 0 ? fq.pop_front() : 20'hXXXXX);
		rdSeen <= regRd;
	end
	initial begin
		#100000;
		failures++;
		$display("BAD %0t timeout", $time);
		give_verdict();
	end
	initial begin
		void'($urandom(32'h9b90));
		do_reset(1'b0);
		for (k = 0; k < 6; k++) begin
			rd(4'(k), 8'h3F & ~(8'h01 << k));
			rd(4'(k + 8), 8'h03);
		end
		rd(4'h6, 8'h00);
		for (k = 0; k < 8; k++) begin
			rs = 3'($urandom % 6);
			rv = 6'($urandom);
			frm(rs, 4'h3, rv, rv & ~(6'h01 << rs), '1, '0, '0, 11'(64 + $urandom % 1455));
		end
		wr(4'h0, 8'h01);
		frm(3'h0, 4'h3, 6'h3F, 6'h01, '1);
		frm(3'h0, 4'hF, 6'h0C, 6'h00, '1);
		wr(4'h8, 8'h07);
		frm(3'h0, 4'hF, 6'h0C, 6'h0C, '1);
		frm(3'h0, 4'hF, 6'h00, 6'h00, '1);
		frm(3'h0, 4'hE, 6'h30, 6'h30, '1);
		frm(3'h0, 4'h3, 6'h01, 6'h00, '0, '0, '0, 11'h064, '0);
		wr(4'h9, 8'h01);
		wr(4'hA, 8'h02);
		wr(4'hB, 8'h00);
		frm(3'h1, 4'h3, 6'h01, 6'h00, '0);
		frm(3'h1, 4'hE, 6'h01, 6'h01, '0);
		frm(3'h2, 4'h3, 6'h01, 6'h00, '1);
		frm(3'h2, 4'hE, 6'h01, 6'h01, '1);
		frm(3'h3, 4'h3, 6'h01, 6'h00, '0);
		frm(3'h0, 4'hE, 6'h0E, 6'h06, '1);
		rd(4'hE, 8'h06);
		frm(3'h5, 4'h3, 6'h0E, 6'h00, '1);
		frm(3'h6, 4'h3, 6'h01, 6'h00, '0);
		wr(4'hC, 8'h0B);
		wr(4'h8, 8'h1F);
		rd(4'hC, 8'h0B);
		rd(4'h8, 8'h07);
		tMode = 1'b1;
		frm(3'h0, 4'h3, 6'h01, 6'h01, '1, 4'h8, 6'h02, 11'h043);
		frm(3'h4, 4'h3, 6'h3F, 6'h21, '1);
		frm(3'h4, 4'h3, 6'h3F, 6'h21, '1, 4'h1, 6'h02);
		frm(3'h4, 4'h3, 6'h3F, 6'h10, '1, 4'h8, 6'h10);
		frm(3'h4, 4'h3, 6'h3F, 6'h00, '1, 4'h8, 6'h00);
		frm(3'h4, 4'h3, 6'h00, 6'h06, '1, 4'h9, 6'h06);
		frm(3'h4, 4'h3, 6'h3F, 6'h21, '0, 4'h4);
		frm(3'h4, 4'h3, 6'h3F, 6'h21, '1, 4'h2, '0, 11'h064, '0);
		frm(3'h4, 4'h3, 6'h3F, 6'h00, '0, '0, '0, 11'h064, '0);
		frm(3'h4, 4'h3, 6'h3F, 6'h00, '0, '0, '0, 11'h043);
		frm(3'h4, 4'h3, 6'h3F, 6'h21, '1, '0, '0, 11'h044);
		frm(3'h4, 4'h3, 6'h3F, 6'h00, '0, '0, '0, 11'h5F3);
		tMode = 1'b0;
		do_reset(1'b1);
		for (k = 8; k < 14; k++)
			rd(4'(k), 8'h00);
		frm(3'h0, 4'h3, 6'h3F, 6'h00, '0);
		@(posedge core_clk);
		chk(20'(fq.size()), 20'h00000);
		give_verdict();
	end
endmodule
bind sip_ingress_policy sip_policy_monitor sip_policy_monitor_inst (.core_clk(core_clk),
	.resetn(resetn), .frameReq(frameReq), .frameRes(frameRes));
